// >>> rtl/lhc_pkg.sv
// What this block does
// - Feedback window exit holds balance loop
// - Period error over threshold holds balance loop
// - Phase count change holds balance loop
// - Balance hold time, 100us per count
// - Frequency register bit 15 reads zero
// - Feedback window exit holds frequency loop
// - Phase count change holds frequency loop
// - Voltage step holds frequency loop
// - Frequency hold time, 100us per count
// - Frequency loop runs only when enabled
// - Bits 6:0 give frequency integral gain
// - Period threshold compares absolute deviation, 80ns/count
package lhc_pkg;
    // Core clock and hold time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_FREQ_KHZ = 20000;
    localparam int HOLD_STEP_US = 100;
    localparam int HOLD_TICK_CYCLES = HOLD_STEP_US * CLK_FREQ_KHZ / 1000;
    localparam int PRE_W = 11;

    // Feedback window, voltage codes are 1 mV per count
    localparam int VOLT_LSB_MV = 1;
    localparam int FB_LOW_MARGIN_MV = 25;
    localparam int FB_HIGH_MARGIN_MV = 20;
    localparam int FB_LOW_MARGIN = FB_LOW_MARGIN_MV / VOLT_LSB_MV;
    localparam int FB_HIGH_MARGIN = FB_HIGH_MARGIN_MV / VOLT_LSB_MV;
    localparam int VOLT_W = 12;

    // Period measurement in core cycles, threshold in 80 ns counts
    localparam int PERIOD_W = 16;
    localparam int THR_W = 7;
    localparam int THR_LSB_NS = 80;
    localparam int PRD_CMP_W = 24;

    // Command codes of the two registers
    localparam logic [7:0] CMD_BALANCE = 8'h31;
    localparam logic [7:0] CMD_FREQ = 8'h32;

    // Balance register fields
    localparam int BAL_FB_BIT = 7;
    localparam int BAL_PRD_BIT = 6;
    localparam int BAL_PHASE_BIT = 5;
    localparam int BAL_STEP_BIT = 4;
    localparam int BAL_DUR_LSB = 0;
    localparam logic [7:0] BAL_RESET = 8'h00;

    // Frequency register fields
    localparam int FRQ_RESV_BIT = 15;
    localparam int FRQ_FB_BIT = 14;
    localparam int FRQ_PHASE_BIT = 13;
    localparam int FRQ_STEP_BIT = 12;
    localparam int FRQ_DUR_LSB = 8;
    localparam int FRQ_EN_BIT = 7;
    localparam int FRQ_GAIN_LSB = 0;
    localparam int GAIN_W = 7;
    localparam int DUR_W = 4;
    localparam logic [14:0] FRQ_RESET = 15'h0000;
    localparam int PHASE_W = 3;
endpackage

// >>> rtl/lhc_hold_timer.sv
`timescale 1ns/1ps
// Retriggerable hold timer in 100 us steps
module lhc_hold_timer
    import lhc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic trigger, // Level, reloads while high
    input wire logic [DUR_W-1:0] duration,
    output logic hold
);
    logic [DUR_W-1:0] cnt; // Steps left
    logic [DUR_W-1:0] next_cnt;
    logic [PRE_W-1:0] pre; // Cycles inside a step
    logic [PRE_W-1:0] next_pre;
    logic next_hold;

    // Prescaler restarts with each trigger so the first step is whole
    always_comb begin
        next_cnt = cnt;
        next_pre = pre;
        if (trigger) begin
            next_cnt = duration;
            next_pre = '0;
        end else if (cnt != '0) begin
            if (pre == PRE_W'(HOLD_TICK_CYCLES - 1)) begin
                next_pre = '0;
                next_cnt = cnt - 1'b1;
            end else begin
                next_pre = pre + 1'b1;
            end
        end
        next_hold = (next_cnt != '0);
    end

    // State registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            pre <= '0;
            hold <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pre <= next_pre;
            hold <= next_hold;
        end
    end

    // Helper: hold length since last trigger and duration then loaded
    logic [15:0] len;
    logic [DUR_W-1:0] dur_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            len <= '0;
            dur_q <= '0;
        end else if (trigger) begin
            len <= '0;
            dur_q <= duration;
        end else if (hold) begin
            len <= len + 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_hold_length: assert property (
        $fell(hold) |-> len == 16'(dur_q * HOLD_TICK_CYCLES))
        else $error("hold length differs from programmed time");
    chk_retrigger_restart: assert property (
        trigger && duration != '0 |=> hold && len == '0)
        else $error("trigger did not restart hold timer");
endmodule

// >>> rtl/lhc_loop_hold_control.sv
`timescale 1ns/1ps
// Loop hold control registers and hold timers
module lhc_loop_hold_control
    import lhc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port from the serial command engine
    input wire logic [7:0] reg_cmd,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Loop conditions from the control core
    input wire logic [VOLT_W-1:0] feedback_voltage,
    input wire logic [VOLT_W-1:0] output_reference,
    input wire logic [PERIOD_W-1:0] actual_period,
    input wire logic [PERIOD_W-1:0] configured_period,
    input wire logic [THR_W-1:0] period_error_threshold,
    input wire logic [PHASE_W-1:0] active_phases,
    input wire logic dynamic_voltage_change,
    // Loop controls
    output logic balance_hold,
    output logic freq_hold,
    output logic freq_loop_run,
    output logic [GAIN_W-1:0] freq_loop_integral_gain
);
    // Register address match, shared by write and read paths
    function automatic logic reg_hit(input logic [7:0] cmd,
                                     input logic [7:0] code);
        reg_hit = (cmd == code);
    endfunction

    // Absolute deviation of two periods
    function automatic logic [PERIOD_W-1:0] abs_diff(
        input logic [PERIOD_W-1:0] a, input logic [PERIOD_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    logic [7:0] bal_reg; // Balance hold control
    logic [7:0] next_bal_reg;
    logic [14:0] frq_reg; // Frequency control, bit 15 not stored
    logic [14:0] next_frq_reg;
    logic [15:0] next_rdata;

    // Register writes and read capture
    always_comb begin
        next_bal_reg = bal_reg;
        next_frq_reg = frq_reg;
        next_rdata = reg_rdata;
        if (reg_wr && reg_hit(reg_cmd, CMD_BALANCE)) begin
            next_bal_reg = reg_wdata[7:0];
        end
        if (reg_wr && reg_hit(reg_cmd, CMD_FREQ)) begin
            next_frq_reg = reg_wdata[14:0];
        end
        if (reg_rd) begin
            if (reg_hit(reg_cmd, CMD_BALANCE)) begin
                next_rdata = {8'h00, bal_reg};
            end else if (reg_hit(reg_cmd, CMD_FREQ)) begin
                next_rdata = {1'b0, frq_reg};
            end else begin
                // Unknown code reads as zero
                next_rdata = 16'h0000;
            end
        end
    end

    // Register storage
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bal_reg <= BAL_RESET;
            frq_reg <= FRQ_RESET;
            reg_rdata <= 16'h0000;
        end else begin
            bal_reg <= next_bal_reg;
            frq_reg <= next_frq_reg;
            reg_rdata <= next_rdata;
        end
    end

    // Field views
    logic [DUR_W-1:0] bal_dur;
    logic [DUR_W-1:0] frq_dur;
    logic frq_en;
    assign bal_dur = bal_reg[BAL_DUR_LSB +: DUR_W];
    assign frq_dur = frq_reg[FRQ_DUR_LSB +: DUR_W];
    assign frq_en = frq_reg[FRQ_EN_BIT];

    // Feedback window: 13 bits so the margin sums never wrap
    logic fb_low;
    logic fb_high;
    logic fb_out;
    assign fb_low = ({1'b0, feedback_voltage} + 13'(FB_LOW_MARGIN))
                    < {1'b0, output_reference};
    assign fb_high = {1'b0, feedback_voltage}
                     > ({1'b0, output_reference} + 13'(FB_HIGH_MARGIN));
    assign fb_out = fb_low | fb_high;

    // Period error: both sides scaled to ns, either sign counts
    logic [PERIOD_W-1:0] prd_dev;
    logic [PRD_CMP_W-1:0] prd_dev_ns;
    logic [PRD_CMP_W-1:0] thr_ns;
    logic prd_err;
    assign prd_dev = abs_diff(actual_period, configured_period);
    assign prd_dev_ns = PRD_CMP_W'(prd_dev) * PRD_CMP_W'(CLK_PERIOD_NS);
    assign thr_ns = PRD_CMP_W'(period_error_threshold)
                    * PRD_CMP_W'(THR_LSB_NS);
    assign prd_err = prd_dev_ns > thr_ns;

    // Phase count change, compared with the count one cycle ago
    logic [PHASE_W-1:0] phases_q;
    logic phases_seen; // First sample taken since reset
    logic phase_chg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phases_q <= '0;
            phases_seen <= 1'b0;
        end else begin
            phases_q <= active_phases;
            phases_seen <= 1'b1;
        end
    end
    // Reset value of the copy is not the pin level, so the first
    // comparison after reset would be a false change; mask it
    assign phase_chg = phases_seen && (active_phases != phases_q);

    // Hold triggers; each stays level so the timer reloads meanwhile
    logic [1:0] trig;
    logic [DUR_W-1:0] dur [2];
    logic [1:0] hold_w;
    always_comb begin
        trig[0] = (bal_reg[BAL_FB_BIT] & fb_out)
                | (bal_reg[BAL_PRD_BIT] & prd_err)
                | (bal_reg[BAL_PHASE_BIT] & phase_chg)
                | (bal_reg[BAL_STEP_BIT] & dynamic_voltage_change);
        trig[1] = (frq_reg[FRQ_FB_BIT] & fb_out)
                | (frq_reg[FRQ_PHASE_BIT] & phase_chg)
                | (frq_reg[FRQ_STEP_BIT] & dynamic_voltage_change);
        dur[0] = bal_dur;
        dur[1] = frq_dur;
    end

    // One retriggerable timer per loop
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_timer
            lhc_hold_timer u_timer (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .trigger(trig[gi]),
                .duration(dur[gi]),
                .hold(hold_w[gi])
            );
        end
    endgenerate
    assign balance_hold = hold_w[0];
    assign freq_hold = hold_w[1];

    // Frequency loop run gate: held loop keeps its integrator frozen
    logic next_run;
    logic [GAIN_W-1:0] next_gain;
    always_comb begin
        next_run = frq_en & ~hold_w[1];
        next_gain = frq_reg[FRQ_GAIN_LSB +: GAIN_W];
    end

    // Loop control outputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_loop_run <= 1'b0;
            freq_loop_integral_gain <= '0;
        end else begin
            freq_loop_run <= next_run;
            freq_loop_integral_gain <= next_gain;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_bal_armed;
        bal_dur != '0;
    endsequence
    sequence s_frq_armed;
        frq_dur != '0;
    endsequence

    chk_bal_fb_hold: assert property (
        s_bal_armed and (bal_reg[BAL_FB_BIT] && fb_out) |=> balance_hold)
        else $error("feedback exit did not hold balance loop");
    // Long side of the period worked out apart from the datapath
    chk_bal_prd_hold: assert property (
        s_bal_armed and (bal_reg[BAL_PRD_BIT]
        && 32'(actual_period) * CLK_PERIOD_NS
        > 32'(configured_period) * CLK_PERIOD_NS
        + 32'(period_error_threshold) * THR_LSB_NS) |=> balance_hold)
        else $error("period error did not hold balance loop");
    chk_bal_phase_hold: assert property (
        s_bal_armed and (bal_reg[BAL_PHASE_BIT]
        && $changed(active_phases)) |=> balance_hold)
        else $error("phase change did not hold balance loop");
    chk_bal_step_hold: assert property (
        s_bal_armed and (bal_reg[BAL_STEP_BIT]
        && dynamic_voltage_change) |=> balance_hold)
        else $error("voltage step did not hold balance loop");
    chk_resv_bit_zero: assert property (
        reg_rd && reg_cmd == CMD_FREQ |=> reg_rdata[FRQ_RESV_BIT] == 1'b0
        && reg_rdata[14:0] == $past(frq_reg))
        else $error("reserved frequency bit not read as zero");
    chk_frq_fb_hold: assert property (
        s_frq_armed and (frq_reg[FRQ_FB_BIT] && fb_out) |=> freq_hold)
        else $error("feedback exit did not hold frequency loop");
    chk_frq_phase_hold: assert property (
        s_frq_armed and (frq_reg[FRQ_PHASE_BIT]
        && $changed(active_phases)) |=> freq_hold)
        else $error("phase change did not hold frequency loop");
    chk_frq_step_hold: assert property (
        s_frq_armed and (frq_reg[FRQ_STEP_BIT]
        && dynamic_voltage_change) |=> freq_hold)
        else $error("voltage step did not hold frequency loop");
    chk_run_needs_enable: assert property (
        !frq_en |=> !freq_loop_run)
        else $error("frequency loop ran while disabled");
    chk_gain_follows_reg: assert property (
        reg_wr && reg_cmd == CMD_FREQ ##1 !(reg_wr && reg_cmd == CMD_FREQ)
        |=> freq_loop_integral_gain == $past(reg_wdata[6:0], 2))
        else $error("integral gain does not follow register");
    chk_hold_freezes: assert property (
        freq_hold |=> !freq_loop_run)
        else $error("frequency loop ran during hold");
endmodule

// >>> dv/loop_hold_control_test.sv
`timescale 1ns/1ps
// Self-checking bench for the loop hold control registers and timers
module loop_hold_control_test;
    import lhc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_cmd = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [VOLT_W-1:0] feedback_voltage = 12'd1000; // Inside the window
    logic [VOLT_W-1:0] output_reference = 12'd1000;
    logic [PERIOD_W-1:0] actual_period = 16'd100;
    logic [PERIOD_W-1:0] configured_period = 16'd100;
    logic [THR_W-1:0] period_error_threshold = 7'd5; // 400 ns
    logic [PHASE_W-1:0] active_phases = 3'd2;
    logic dynamic_voltage_change = 1'b0;
    logic balance_hold;
    logic freq_hold;
    logic freq_loop_run;
    logic [GAIN_W-1:0] freq_loop_integral_gain;
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'hf2b8d680;
    int exp_bal = 0; // Model of the balance register
    int exp_frq = 0; // Model of the frequency register
    int test_no = 0;
    logic counting = 1'b0;
    // Four-state counters, so an unknown hold never passes as zero
    logic [31:0] bal_cnt;
    logic [31:0] frq_cnt;
    logic [31:0] low_cnt;

    lhc_loop_hold_control lhc_loop_hold_control_inst (
        .core_clk(core_clk), .rst_b(rst_b), .reg_cmd(reg_cmd),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .feedback_voltage(feedback_voltage),
        .output_reference(output_reference),
        .actual_period(actual_period),
        .configured_period(configured_period),
        .period_error_threshold(period_error_threshold),
        .active_phases(active_phases),
        .dynamic_voltage_change(dynamic_voltage_change),
        .balance_hold(balance_hold), .freq_hold(freq_hold),
        .freq_loop_run(freq_loop_run),
        .freq_loop_integral_gain(freq_loop_integral_gain)
    );

    // 20 MHz core clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // Hold cycle counters, sampled at the falling edge where all is settled
    always @(negedge core_clk) begin
        if (counting) begin
            bal_cnt <= bal_cnt + balance_hold;
            frq_cnt <= frq_cnt + freq_hold;
            low_cnt <= low_cnt + !freq_loop_run;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Write strobe for one cycle; entered and left at a falling edge
    // Idle cycle after it, so back to back calls never re-raise a strobe
    // in the step that lowered it
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        reg_cmd = c;
        reg_wdata = d;
        reg_wr = 1'b1;
        if (c == CMD_BALANCE) exp_bal = d & 16'h00ff;
        if (c == CMD_FREQ) exp_frq = d & 16'h7fff;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        reg_cmd = c;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk("reg_rdata", {16'h0000, exp}, {16'h0000, reg_rdata});
        @(negedge core_clk);
    endtask

    // One-cycle condition; phase change is a lasting step
    task automatic pulse(input int kind);
        case (kind)
            0: feedback_voltage = 12'd974; // Just under ref - 25
            1: feedback_voltage = 12'd1021; // Just over ref + 20
            2: actual_period = 16'd109; // 450 ns above 400 ns
            3: active_phases = active_phases + 3'd1;
            4: dynamic_voltage_change = 1'b1;
            5: feedback_voltage = 12'd975; // On the edge, no trigger
            default: actual_period = 16'd108; // 400 ns, not above
        endcase
        @(negedge core_clk);
        feedback_voltage = 12'd1000;
        actual_period = 16'd100;
        dynamic_voltage_change = 1'b0;
    endtask

    // Program one loop, fire a condition, count held cycles
    task automatic run(input logic [7:0] c, input logic [15:0] v,
                       input int kind, input bit retrig, input int exp);
        wr(CMD_BALANCE, (c == CMD_BALANCE) ? v : 16'h0000);
        wr(CMD_FREQ, (c == CMD_FREQ) ? (v | 16'h0080) : 16'h0080);
        bal_cnt = 0;
        frq_cnt = 0;
        low_cnt = 0;
        counting = 1'b1;
        pulse(kind);
        if (retrig) begin
            repeat (1000) @(negedge core_clk);
            pulse(kind);
        end
        repeat (exp + 100) @(negedge core_clk);
        counting = 1'b0;
        chk("balance_hold cycles", (c == CMD_BALANCE) ? exp : 0,
            bal_cnt);
        chk("freq_hold cycles", (c == CMD_FREQ) ? exp : 0, frq_cnt);
        chk("freq_loop_run low", (c == CMD_FREQ) ? exp : 0, low_cnt);
        test_no++;
        $display("hold test %0d done", test_no);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [15:0] d;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        rd(CMD_BALANCE, 16'h0000);
        rd(CMD_FREQ, 16'h0000);
        rd(8'h33, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(CMD_BALANCE, d);
            wr(CMD_FREQ, d);
            rd(CMD_BALANCE, exp_bal[15:0]);
            rd(CMD_FREQ, exp_frq[15:0]);
            chk("gain", {25'd0, d[6:0]},
                {25'd0, freq_loop_integral_gain});
            chk("run", {31'd0, d[7]}, {31'd0, freq_loop_run});
        end
        // Unknown code write must leave both registers alone
        wr(8'h33, 16'hffff);
        rd(CMD_BALANCE, exp_bal[15:0]);
        rd(CMD_FREQ, exp_frq[15:0]);
        $display("register test done");
        wr(CMD_FREQ, 16'h0000);
        wr(CMD_BALANCE, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk("run off", 0, {31'd0, freq_loop_run});
        run(CMD_BALANCE, 16'h0081, 0, 0, HOLD_TICK_CYCLES);
        // Second trigger lands 1001 cycles after the first, full time again
        run(CMD_BALANCE, 16'h0081, 1, 1, HOLD_TICK_CYCLES + 1001);
        run(CMD_BALANCE, 16'h0042, 2, 0, 2 * HOLD_TICK_CYCLES);
        run(CMD_BALANCE, 16'h0041, 6, 0, 0);
        run(CMD_BALANCE, 16'h0021, 3, 0, HOLD_TICK_CYCLES);
        run(CMD_BALANCE, 16'h0011, 4, 0, HOLD_TICK_CYCLES);
        run(CMD_BALANCE, 16'h0071, 0, 0, 0);
        run(CMD_BALANCE, 16'h0080, 0, 0, 0);
        run(CMD_FREQ, 16'h4100, 5, 0, 0);
        run(CMD_FREQ, 16'h4100, 0, 0, HOLD_TICK_CYCLES);
        run(CMD_FREQ, 16'h2100, 3, 0, HOLD_TICK_CYCLES);
        run(CMD_FREQ, 16'h1100, 4, 0, HOLD_TICK_CYCLES);
        run(CMD_FREQ, 16'h3100, 0, 0, 0);
        run(CMD_FREQ, 16'h7100, 2, 0, 0);
        run(CMD_FREQ, 16'h4200, 1, 0, 2 * HOLD_TICK_CYCLES);
        summarize();
    end

    // Watchdog, well beyond the roughly 25700 cycles the tests need
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen timeout");
        summarize();
    end
endmodule
